// ### wgs_sequencer.sv
// Gated playback and segment sequencer for an arbitrary waveform generator.
// Assumes trace memory turns play_addr into samples, and trigger pins are
// asynchronous to clk.
// Notes on behaviour
// - Gated mode leaves quiescence on gate active, plays continuously, then returns.
// - Gate stop either finishes the current cycle or stops at once.
// - A sequence holds two to 4096 segments, each naming a stored trace.
// - Segments are indexed from zero to sequence length minus one.
// - Each segment repeats per loop count, then advances under its condition.
// - Loop count takes 1 to 1,048,576; zero means loop forever.
// - Continuous sequence restarts from segment zero after the final segment.
// - Triggered sequence restarts only on a start trigger.
// - Loop zero, finishing style: on advance trigger finish cycle, then advance.
// - Loop zero, immediate style: on advance trigger switch segment at once.
// - Nonzero loop with triggered start: play count, hold last sample until trigger.
// - Nonzero loop, automatic: play count, then go straight to next segment.
// - Reset gives automatic advance, finishing style and edge sense.
// - Start and advance triggers default to internal 1 kHz generator.
// - Start trigger launches and restarts; advance trigger only branches segments.
// - Ended triggered sequence holds last sample until a new start trigger.
// - Polarity picks rising or falling edge of external triggers.
// - Edge sense needs the trigger to go inactive before a new restart.
// - Triggered mode rests at first sample, plays whole cycles, returns there.
`timescale 1ns/1ps
`default_nettype none

module wgs_sequencer #(
    parameter int INT_TRIG_DIV = wgs_pkg::INT_TRIG_CYCLES
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [wgs_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [wgs_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [wgs_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [wgs_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic start_trig_in,
    input wire logic adv_trig_in,
    input wire logic gate_in,
    output logic [wgs_pkg::TADDR_W-1:0] play_addr,
    output logic play_active
);
    import wgs_pkg::*;

    // Byte-lane merge of a write into an old word
    function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old,
                                                input logic [DATA_W-1:0] nw,
                                                input logic [3:0] strb);
        logic [DATA_W-1:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    // -----------------------------------------------------------------
    // Register bus
    // -----------------------------------------------------------------
    logic [C_WIDTH-1:0] ctrl_reg;
    logic [SLEN_W-1:0] seq_len_reg;
    logic [SEG_W-1:0] seg_idx_reg;
    logic [DATA_W-1:0] base_stage_reg;
    logic [DATA_W-1:0] tlen_stage_reg;
    logic [TADDR_W-1:0] seg_base_mem [SEG_DEPTH];
    logic [TLEN_W-1:0] seg_tlen_mem [SEG_DEPTH];
    logic [LOOP_W-1:0] seg_loop_mem [SEG_DEPTH];
    logic [SEG_DEPTH-1:0] seg_trig_reg;
    logic [DATA_W-1:0] wr_word;
    logic [DATA_W-1:0] old_word;
    logic [DATA_W-1:0] rd_word;
    logic wr_go;
    logic rd_ok;
    logic [SLEN_W-1:0] len_wr;
    wgs_state_e state_reg;
    wgs_state_e state_next;
    logic [SEG_W-1:0] cur_reg;

    // Write address and data are taken together, one write at a time
    assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
    assign s_axi_awready = wr_go;
    assign s_axi_wready = wr_go;
    assign s_axi_arready = !s_axi_rvalid;

    // Current contents of the addressed writable word
    always_comb begin
        case (s_axi_awaddr)
            CTRL_OFS: old_word = {{(DATA_W-C_WIDTH){1'b0}}, ctrl_reg};
            SEQ_LEN_OFS: old_word = {{(DATA_W-SLEN_W){1'b0}}, seq_len_reg};
            SEG_IDX_OFS: old_word = {{(DATA_W-SEG_W){1'b0}}, seg_idx_reg};
            SEG_BASE_OFS: old_word = base_stage_reg;
            SEG_TLEN_OFS: old_word = tlen_stage_reg;
            default: old_word = '0;
        endcase
    end
    assign wr_word = merge(old_word, s_axi_wdata, s_axi_wstrb);
    assign len_wr = wr_word[SLEN_W-1:0];

    // Control and staging registers
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_reg <= CTRL_RST;
            seq_len_reg <= SEQ_LEN_MIN;
            seg_idx_reg <= '0;
            base_stage_reg <= '0;
            tlen_stage_reg <= '0;
        end else if (wr_go) begin
            case (s_axi_awaddr)
                CTRL_OFS: ctrl_reg <= wr_word[C_WIDTH-1:0];
                SEQ_LEN_OFS: begin
                    // Length clamped to the legal range of two to 4096
                    if (wr_word > DATA_W'(SEQ_LEN_MAX)) begin
                        seq_len_reg <= SEQ_LEN_MAX;
                    end else if (len_wr < SEQ_LEN_MIN) begin
                        seq_len_reg <= SEQ_LEN_MIN;
                    end else begin
                        seq_len_reg <= len_wr;
                    end
                end
                SEG_IDX_OFS: seg_idx_reg <= wr_word[SEG_W-1:0];
                SEG_BASE_OFS: base_stage_reg <= wr_word;
                SEG_TLEN_OFS: tlen_stage_reg <= wr_word;
                default: ;
            endcase
        end
    end

    // Segment table: written as one entry on the loop word
    always_ff @(posedge clk) begin
        if (wr_go && s_axi_awaddr == SEG_LOOP_OFS) begin
            seg_base_mem[seg_idx_reg] <= base_stage_reg[TADDR_W-1:0];
            seg_tlen_mem[seg_idx_reg] <= tlen_stage_reg[TLEN_W-1:0];
            seg_loop_mem[seg_idx_reg] <= wr_word[LOOP_W-1:0];
        end
    end

    // Start-condition flags reset to automatic
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            seg_trig_reg <= '0;
        end else if (wr_go && s_axi_awaddr == SEG_LOOP_OFS) begin
            seg_trig_reg[seg_idx_reg] <= wr_word[L_TRIG_BIT];
        end
    end

    // Write response
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (s_axi_awaddr <= SEG_LOOP_OFS && s_axi_awaddr[1:0] == 2'h0) ?
                           RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Read decode
    always_comb begin
        rd_ok = 1'b1;
        case (s_axi_araddr)
            CTRL_OFS: rd_word = {{(DATA_W-C_WIDTH){1'b0}}, ctrl_reg};
            SEQ_LEN_OFS: rd_word = {{(DATA_W-SLEN_W){1'b0}}, seq_len_reg};
            SEG_IDX_OFS: rd_word = {{(DATA_W-SEG_W){1'b0}}, seg_idx_reg};
            SEG_BASE_OFS: rd_word = base_stage_reg;
            SEG_TLEN_OFS: rd_word = tlen_stage_reg;
            SEG_LOOP_OFS: rd_word = '0;
            STATUS_OFS: begin
                rd_word = '0;
                rd_word[0] = (state_reg == ST_PLAY);
                rd_word[1] = (state_reg == ST_SEG_WAIT);
                rd_word[2] = (state_reg == ST_END_HOLD);
                rd_word[ST_SEG_LO +: SEG_W] = cur_reg;
            end
            default: begin
                rd_word = '0;
                rd_ok = 1'b0;
            end
        endcase
    end

    // Read response
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // -----------------------------------------------------------------
    // Triggers
    // -----------------------------------------------------------------
    logic [2:0] sync1_reg;
    logic [2:0] sync2_reg;
    logic [2:0] act_d_reg;
    logic [2:0] act;
    logic [31:0] div_reg;
    logic int_tick;
    logic ext_start_hit;
    logic ext_adv_hit;
    logic start_hit;
    logic adv_hit;
    logic gate_act;

    // Two-flop synchronisers, then polarity and edge memory
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            act_d_reg <= '0;
        end else begin
            sync1_reg <= {gate_in, adv_trig_in, start_trig_in};
            sync2_reg <= sync1_reg;
            act_d_reg <= act;
        end
    end
    assign act = sync2_reg ^ {3{ctrl_reg[C_POL_NEG]}};

    // Edge sense needs inactive-then-active; level sense takes the level
    assign ext_start_hit = ctrl_reg[C_SENSE_LVL] ? act[0] : act[0] && !act_d_reg[0];
    assign ext_adv_hit = ctrl_reg[C_SENSE_LVL] ? act[1] : act[1] && !act_d_reg[1];
    assign gate_act = act[2];

    // Internal 1 kHz trigger generator
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            div_reg <= '0;
        end else if (div_reg == 32'(INT_TRIG_DIV - 1)) begin
            div_reg <= '0;
        end else begin
            div_reg <= div_reg + 32'h1;
        end
    end
    assign int_tick = (div_reg == 32'(INT_TRIG_DIV - 1));
    assign start_hit = ctrl_reg[C_START_EXT] ? ext_start_hit : int_tick;
    assign adv_hit = ctrl_reg[C_ADV_EXT] ? ext_adv_hit : int_tick;

    // -----------------------------------------------------------------
    // Playback state machine
    // -----------------------------------------------------------------
    logic [1:0] mode;
    logic [TLEN_W-1:0] ptr_reg;
    logic [LOOP_W-1:0] cnt_reg;
    logic adv_pend_reg;
    logic [TADDR_W-1:0] seg_base;
    logic [TLEN_W-1:0] seg_last;
    logic [LOOP_W-1:0] seg_loop;
    logic cyc_end;
    logic loop_inf;
    logic loop_done;
    logic last_seg;
    logic is_seq;
    logic adv;
    logic wrap;

    assign mode = ctrl_reg[C_MODE_LO +: 2];
    assign is_seq = (mode == MODE_SEQ_CONT) || (mode == MODE_SEQ_TRIG);
    assign seg_base = seg_base_mem[cur_reg];
    assign seg_last = (seg_tlen_mem[cur_reg] == '0) ? '0 : seg_tlen_mem[cur_reg] - 1'b1;
    assign seg_loop = seg_loop_mem[cur_reg];
    assign cyc_end = (ptr_reg == seg_last);
    assign loop_inf = (seg_loop == '0);
    assign loop_done = !loop_inf && (cnt_reg + 1'b1 == seg_loop);
    assign last_seg = ({1'b0, cur_reg} == seq_len_reg - 1'b1);

    // Next state, advance and cycle-wrap decisions
    always_comb begin
        state_next = state_reg;
        adv = 1'b0;
        wrap = 1'b0;
        case (state_reg)
            ST_IDLE: begin
                if (ctrl_reg[C_RUN]) begin
                    if (mode == MODE_GATED) begin
                        if (gate_act) state_next = ST_PLAY;
                    end else if (start_hit) begin
                        state_next = ST_PLAY;
                    end
                end
            end
            ST_PLAY: begin
                if (!ctrl_reg[C_RUN]) begin
                    state_next = ST_IDLE;
                end else if (mode == MODE_GATED) begin
                    if (!gate_act && (ctrl_reg[C_GATE_IMM] || cyc_end)) begin
                        state_next = ST_IDLE;
                    end else if (cyc_end) begin
                        wrap = 1'b1;
                    end
                end else if (mode == MODE_TRACE_TRIG) begin
                    if (cyc_end && loop_done) begin
                        state_next = ST_IDLE;
                    end else if (cyc_end) begin
                        wrap = 1'b1;
                    end
                end else if (loop_inf && adv_hit && ctrl_reg[C_SEQ_IMM]) begin
                    adv = 1'b1;
                end else if (cyc_end) begin
                    if (loop_inf) begin
                        adv = adv_pend_reg || adv_hit;
                        wrap = !adv;
                    end else if (loop_done && seg_trig_reg[cur_reg]) begin
                        state_next = ST_SEG_WAIT;
                    end else begin
                        adv = loop_done;
                        wrap = !loop_done;
                    end
                end
                if (adv && last_seg && mode == MODE_SEQ_TRIG) begin
                    state_next = ST_END_HOLD;
                end
            end
            ST_SEG_WAIT: begin
                if (!ctrl_reg[C_RUN]) begin
                    state_next = ST_IDLE;
                end else if (adv_hit) begin
                    adv = 1'b1;
                    state_next = (last_seg && mode == MODE_SEQ_TRIG) ? ST_END_HOLD : ST_PLAY;
                end
            end
            ST_END_HOLD: begin
                if (!ctrl_reg[C_RUN]) begin
                    state_next = ST_IDLE;
                end else if (start_hit) begin
                    state_next = ST_PLAY;
                end
            end
            default: state_next = ST_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Segment, sample pointer and loop counter
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cur_reg <= '0;
            ptr_reg <= '0;
            cnt_reg <= '0;
        end else if (state_reg == ST_IDLE || !is_seq ||
                     (state_reg == ST_END_HOLD && state_next == ST_PLAY)) begin
            if (state_reg != ST_PLAY || state_next != ST_PLAY) begin
                cur_reg <= '0;
                ptr_reg <= '0;
                cnt_reg <= '0;
            end else if (wrap) begin
                ptr_reg <= '0;
                cnt_reg <= cnt_reg + 1'b1;
            end else begin
                ptr_reg <= ptr_reg + 1'b1;
            end
        end else if (adv && state_next != ST_END_HOLD) begin
            cur_reg <= last_seg ? '0 : cur_reg + 1'b1;
            ptr_reg <= '0;
            cnt_reg <= '0;
        end else if (wrap) begin
            ptr_reg <= '0;
            cnt_reg <= cnt_reg + 1'b1;
        end else if (state_reg == ST_PLAY && state_next == ST_PLAY && !adv) begin
            ptr_reg <= ptr_reg + 1'b1;
        end
    end

    // Advance trigger remembered until the finishing cycle ends
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            adv_pend_reg <= 1'b0;
        end else if (adv || state_reg != ST_PLAY) begin
            adv_pend_reg <= 1'b0;
        end else if (adv_hit && loop_inf && is_seq) begin
            adv_pend_reg <= 1'b1;
        end
    end

    // Trace memory address and play flag
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            play_addr <= '0;
            play_active <= 1'b0;
        end else begin
            play_addr <= seg_base + TADDR_W'(ptr_reg);
            play_active <= (state_reg == ST_PLAY);
        end
    end

    // -----------------------------------------------------------------
    // Checks
    // -----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    sequence gate_drop_imm;
        state_reg == ST_PLAY && mode == MODE_GATED && ctrl_reg[C_RUN] &&
            !gate_act && ctrl_reg[C_GATE_IMM];
    endsequence

    gate_start_a: assert property (state_reg == ST_IDLE && ctrl_reg[C_RUN] &&
        mode == MODE_GATED && gate_act |=> state_reg == ST_PLAY)
        else $error("gate did not start playback");
    gate_stop_imm_a: assert property (gate_drop_imm |=> state_reg == ST_IDLE ##1 !play_active)
        else $error("immediate gate stop missed");
    gate_finish_a: assert property (state_reg == ST_PLAY && mode == MODE_GATED &&
        ctrl_reg[C_RUN] && !ctrl_reg[C_GATE_IMM] && !cyc_end |=> state_reg == ST_PLAY)
        else $error("finishing gate stopped mid cycle");
    seq_len_range_a: assert property (seq_len_reg >= SEQ_LEN_MIN && seq_len_reg <= SEQ_LEN_MAX)
        else $error("sequence length out of range");
    seg_index_a: assert property ({1'b0, cur_reg} < seq_len_reg || !is_seq)
        else $error("segment index beyond length");
    cont_wrap_a: assert property (adv && last_seg && mode == MODE_SEQ_CONT &&
        state_reg == ST_PLAY |=> cur_reg == '0 && ptr_reg == '0)
        else $error("continuous sequence did not restart");
    end_hold_a: assert property (state_reg == ST_END_HOLD && !start_hit && ctrl_reg[C_RUN]
        |=> state_reg == ST_END_HOLD && $stable(play_addr))
        else $error("ended sequence did not hold");
    imm_adv_a: assert property (state_reg == ST_PLAY && is_seq && ctrl_reg[C_RUN] &&
        loop_inf && adv_hit && ctrl_reg[C_SEQ_IMM] && !last_seg
        |=> ptr_reg == '0 && cur_reg == $past(cur_reg) + 1'b1)
        else $error("immediate advance did not switch");
    wait_hold_a: assert property (state_reg == ST_SEG_WAIT && !adv_hit && ctrl_reg[C_RUN]
        |=> state_reg == ST_SEG_WAIT)
        else $error("segment left wait without trigger");
    idle_rest_a: assert property (state_reg == ST_IDLE |=> ptr_reg == '0)
        else $error("quiescent level not first sample");

endmodule : wgs_sequencer

`default_nettype wire

// ### wgs_pkg.sv
// Package for the waveform gate and sequencer: register map, fields,
// reset values, modes and timing.
// Assumes a 125 MHz sample clock and a 32-bit AXI4-Lite register bus.
package wgs_pkg;

    // ----------------------------------------
    // Widths
    // ----------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int TADDR_W = 19;     // trace memory address
    localparam int TLEN_W = 20;      // trace length in samples
    localparam int SEG_W = 12;       // segment index
    localparam int SLEN_W = 13;      // sequence length, up to 4096
    localparam int LOOP_W = 21;      // loop count, up to 1,048,576
    localparam int SEG_DEPTH = 4096;

    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
    localparam logic [ADDR_W-1:0] SEQ_LEN_OFS = 8'h04;
    localparam logic [ADDR_W-1:0] SEG_IDX_OFS = 8'h08;
    localparam logic [ADDR_W-1:0] SEG_BASE_OFS = 8'h0c;
    localparam logic [ADDR_W-1:0] SEG_TLEN_OFS = 8'h10;
    localparam logic [ADDR_W-1:0] SEG_LOOP_OFS = 8'h14;
    localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h18;

    // ----------------------------------------
    // Control fields and reset values
    // ----------------------------------------
    localparam int C_RUN = 0;
    localparam int C_MODE_LO = 1;    // two bits
    localparam int C_GATE_IMM = 3;
    localparam int C_SEQ_IMM = 4;
    localparam int C_SENSE_LVL = 5;
    localparam int C_POL_NEG = 6;
    localparam int C_START_EXT = 7;
    localparam int C_ADV_EXT = 8;
    localparam int C_WIDTH = 9;
    localparam logic [C_WIDTH-1:0] CTRL_RST = 9'h000;
    localparam logic [SLEN_W-1:0] SEQ_LEN_MIN = 13'h0002;
    localparam logic [SLEN_W-1:0] SEQ_LEN_MAX = 13'h1000;
    localparam int L_TRIG_BIT = 31;  // segment waits for trigger after its loops
    localparam int ST_SEG_LO = 16;   // status: current segment field

    // ----------------------------------------
    // Modes and states
    // ----------------------------------------
    typedef enum logic [1:0] {
        MODE_GATED = 2'h0,
        MODE_SEQ_CONT = 2'h1,
        MODE_SEQ_TRIG = 2'h2,
        MODE_TRACE_TRIG = 2'h3
    } wgs_mode_e;

    typedef enum {ST_IDLE, ST_PLAY, ST_SEG_WAIT, ST_END_HOLD} wgs_state_e;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ----------------------------------------
    // Timing: internal trigger at 1 kHz
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 8;
    localparam int INT_TRIG_PERIOD_NS = 1000000;
    localparam int INT_TRIG_CYCLES = INT_TRIG_PERIOD_NS / CLK_PERIOD_NS;

endpackage : wgs_pkg

// ### wgs_far_side.sv
// Far-side trigger source: drives the three trigger pins.
// Assumes the bench sets the levels just after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module wgs_far_side (
    input wire logic [2:0] lvl,
    output logic start_trig_in,
    output logic adv_trig_in,
    output logic gate_in
);
    // Pins follow the requested levels
    assign {gate_in, adv_trig_in, start_trig_in} = lvl;
endmodule : wgs_far_side
`default_nettype wire

// ### testbench.sv
// Bench for wgs_sequencer: AXI4-Lite tasks, trigger stimulus, self checks.
// Assumes wgs_far_side drives the trigger pins from requested levels.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import wgs_pkg::*;
    logic clk = 1'b0, rstn = 1'b0, awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
    logic [7:0] aw = 8'h00, ar = 8'h00;
    logic [31:0] wd = 32'h0, rdat;
    logic [2:0] lvl = 3'h0;
    logic awr, wrd, bv, arr, rv, act, st, ad, gt;
    logic [1:0] bresp, rresp;
    logic [18:0] pa;
    int error_cnt = 0, total_checks = 0, cyc = 0;
    // Design with a short internal trigger period, and its trigger source
    wgs_sequencer #(.INT_TRIG_DIV(20)) uut (.clk(clk), .rstn(rstn), .s_axi_awaddr(aw),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
        .s_axi_bready(br), .s_axi_araddr(ar), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
        .start_trig_in(st), .adv_trig_in(ad), .gate_in(gt), .play_addr(pa), .play_active(act));
    wgs_far_side far (.lvl(lvl), .start_trig_in(st), .adv_trig_in(ad), .gate_in(gt));
    // Clock and run-time ceiling
    always #4 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) close_out(1);
    end
    // Compare and count
    task automatic chk(input logic [33:0] s, input logic [33:0] e);
        total_checks++;
        if (s !== e) error_cnt++;
        if (s !== e) $display("wrong value at %0t: got %h want %h", $time, s, e);
    endtask : chk
    // Bus write: address and data offered together, held until taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        aw <= a;
        wd <= d;
        {awv, wv, br} <= 3'h7;
        do @(posedge clk); while (awr !== 1'b1 || wrd !== 1'b1);
        {awv, wv} <= 2'h0;
        do @(posedge clk); while (bv !== 1'b1);
        br <= 1'b0;
        chk(34'(bresp), 34'(RESP_OKAY));
    endtask : wr
    // Bus read, response code and data compared together
    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        @(posedge clk);
        ar <= a;
        {arv, rr} <= 2'h3;
        do @(posedge clk); while (arr !== 1'b1);
        arv <= 1'b0;
        do @(posedge clk); while (rv !== 1'b1);
        rr <= 1'b0;
        chk({rresp, rdat}, e);
    endtask : rd
    // Bounded wait for a trace address
    task automatic wa(input logic [18:0] v, input int lim);
        for (int n = 0; n < lim && pa !== v; n++) @(posedge clk);
        chk(34'(pa), 34'(v));
    endtask : wa
    // One segment table entry
    task automatic seg(input logic [31:0] i, b, l, c);
        wr(SEG_IDX_OFS, i);
        wr(SEG_BASE_OFS, b);
        wr(SEG_TLEN_OFS, l);
        wr(SEG_LOOP_OFS, c);
    endtask : seg
    // Verdict and end of run
    task automatic close_out(input int extra);
        error_cnt += extra;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : close_out
    // Main sequence
    initial begin
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        rd(CTRL_OFS, {RESP_OKAY, 32'h0});
        rd(8'h40, {RESP_SLVERR, 32'h0});
        wr(SEQ_LEN_OFS, 32'h12000);
        rd(SEQ_LEN_OFS, {RESP_OKAY, 32'h1000});
        wr(SEQ_LEN_OFS, 32'h0);
        rd(SEQ_LEN_OFS, {RESP_OKAY, 32'h2});
        seg(32'h0, 32'h100, 32'h2, 32'h1);
        seg(32'h1, 32'h200, 32'h2, 32'h1);
        wr(CTRL_OFS, 32'h3);
        wa(19'h201, 200);
        wa(19'h100, 20);
        wr(CTRL_OFS, 32'h0);
        wr(CTRL_OFS, 32'h185);
        lvl <= 3'h1;
        wa(19'h201, 50);
        repeat (30) @(posedge clk);
        chk({act, 14'h0, pa}, 34'h201);
        rd(STATUS_OFS, {RESP_OKAY, 32'h00010004});
        lvl <= 3'h0;
        repeat (4) @(posedge clk);
        lvl <= 3'h1;
        wa(19'h101, 20);
        wr(CTRL_OFS, 32'h0);
        lvl <= 3'h0;
        seg(32'h0, 32'h100, 32'h40, 32'h0);
        wr(CTRL_OFS, 32'h193);
        lvl <= 3'h1;
        wa(19'h13f, 100);
        wa(19'h104, 20);
        lvl <= 3'h3;
        wa(19'h200, 12);
        wr(CTRL_OFS, 32'h0);
        lvl <= 3'h4;
        wr(CTRL_OFS, 32'h1);
        wa(19'h104, 80);
        lvl <= 3'h0;
        repeat (8) @(posedge clk);
        chk(34'(act), 34'h1);
        repeat (70) @(posedge clk);
        chk(34'(act), 34'h0);
        // Gate with immediate stop
        lvl <= 3'h4;
        wr(CTRL_OFS, 32'h9);
        wa(19'h104, 80);
        lvl <= 3'h0;
        repeat (6) @(posedge clk);
        chk(34'(act), 34'h0);
        // Finishing advance, waiting segment, then level sense
        wr(CTRL_OFS, 32'h0);
        seg(32'h0, 32'h100, 32'h10, 32'h0);
        seg(32'h1, 32'h200, 32'h2, 32'h80000001);
        wr(CTRL_OFS, 32'h183);
        lvl <= 3'h1;
        wa(19'h102, 20);
        lvl <= 3'h2;
        wa(19'h10f, 20);
        wa(19'h201, 8);
        repeat (10) @(posedge clk);
        chk({act, 14'h0, pa}, 34'h201);
        wr(CTRL_OFS, 32'h1a3);
        wa(19'h100, 10);
        wr(CTRL_OFS, 32'h0);
        // Single trace burst on a falling start edge
        lvl <= 3'h1;
        seg(32'h0, 32'h100, 32'h4, 32'h2);
        wr(CTRL_OFS, 32'hc7);
        lvl <= 3'h0;
        wa(19'h103, 20);
        wa(19'h101, 8);
        repeat (12) @(posedge clk);
        chk({act, 14'h0, pa}, 34'h100);
        close_out(0);
    end
endmodule : testbench
`default_nettype wire
